// ==== logic/rcdp_pkg.sv ====
// Shared constants and helpers for the display and processor pin port.
// Assumes one 25 MHz system clock feeding both ends.
`default_nettype none

package rcdp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Pin and field layout
    localparam int DATA_W       = 8;
    localparam int NIB_W        = 4;
    localparam int REG_COUNT    = 16;
    localparam int STAT_W       = 5;
    localparam int PIDX_W       = 3;
    localparam int ADDR_LSB     = 4;
    localparam int NUM_PORTS_DEF = 7;

    localparam logic [DATA_W-1:0] OE_ALL    = 8'hFF;
    localparam logic [DATA_W-1:0] OE_NONE   = 8'h00;
    localparam logic [DATA_W-1:0] OE_LOW_NIB = 8'h0F;
    localparam logic [DATA_W-1:0] OE_HI_NIB = 8'hF0;
    localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
    localparam logic [STAT_W-1:0] STAT_TEST = 5'h1F;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_HZ          = 25_000_000;
    localparam int HOLD_MS         = 30;
    localparam int HOLD_CYCLES_DEF = HOLD_MS * (CLK_HZ / 1000);
    localparam int TEST_SCANS_DEF  = 4;
    localparam int STROBE_CYCLES_DEF = 4;
    localparam int LOAD_CYCLES_DEF = 8;

    ////////////////////////////////////////////////////////////////////////
    // Word packing
    function automatic logic [DATA_W-1:0] disp_word(input logic [PIDX_W-1:0] idx,
                                                     input logic [STAT_W-1:0] stat);
        return {idx, stat};
    endfunction

    function automatic logic [DATA_W-1:0] cpu_word(input logic [NIB_W-1:0] addr,
                                                    input logic [NIB_W-1:0] data);
        return {addr, data};
    endfunction

endpackage

`default_nettype wire

// ==== logic/rcdp_if.sv ====
// Pin bundle between the port device and the processor side.
// Shared data pins are resolved here from both drivers; undriven bits pull high.
`default_nettype none

interface rcdp_if;
    import rcdp_pkg::*;

    logic                display_latch_strobe_n;
    logic                display_hold_strobe;
    logic                data_buffer_drive_enable;
    logic                config_load_reset_n;
    logic                reg_store_n;
    logic                reg_fetch_n;
    logic [DATA_W-1:0]   dev_d_out;
    logic [DATA_W-1:0]   dev_d_oe;
    logic [DATA_W-1:0]   host_d_out;
    logic [DATA_W-1:0]   host_d_oe;
    logic [DATA_W-1:0]   d;

    // Wired resolution with pull-up
    assign d = (dev_d_oe & dev_d_out) | (host_d_oe & host_d_out) | (~dev_d_oe & ~host_d_oe);

    modport device (
        output display_latch_strobe_n,
        output display_hold_strobe,
        output data_buffer_drive_enable,
        input  config_load_reset_n,
        input  reg_store_n,
        input  reg_fetch_n,
        output dev_d_out,
        output dev_d_oe,
        input  d
    );

    modport host (
        input  display_latch_strobe_n,
        input  display_hold_strobe,
        input  data_buffer_drive_enable,
        output config_load_reset_n,
        output reg_store_n,
        output reg_fetch_n,
        output host_d_out,
        output host_d_oe,
        input  d
    );
endinterface

`default_nettype wire

// ==== logic/rcdp_hold_timer.sv ====
// Freeze window timer: runs from start until stop or expiry.
// Assumes start and stop are one-cycle pulses on clk_sys.
`default_nettype none

module rcdp_hold_timer #(
    parameter int HOLD_CYCLES = rcdp_pkg::HOLD_CYCLES_DEF
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic stop,
    output logic      active
);
    import rcdp_pkg::*;

    localparam int CNT_W = $clog2(HOLD_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(HOLD_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (start) begin
            cnt_reg <= CNT_LOAD;
        end else if (stop) begin
            cnt_reg <= '0;  // R07
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - CNT_ONE;  // R07
        end
    end

    assign active = (cnt_reg != '0);
endmodule

`default_nettype wire

// ==== logic/rcdp_device.sv ====
// Device end of the shared display / processor pin port.
// Assumes the far end keeps the pins released outside strobes and load.
//
// Functional notes
// R01: Device drives display latch strobe for latches
// R02: Latch strobe held high during processor strobes
// R03: Display cycles drive all pins: data, port
// R04: Processor cycles: address high nibble, data low
// R05: Pins driven always except under processor strobes; also released while load is held
// R06: Hold strobe pulses high at packet end
// R07: Frozen status until next packet or 30 ms
// R08: Buffer enable steers the external bus transceiver
// R09: Buffer enable high display, low processor/load
// R10: Store strobe writes register named by nibble
// R11: Fetch strobe returns register named by nibble
// R12: Load input low resets and holds everything; config_value and config_valid are cleared only by rst
// R13: Load rising edge latches pins into config
// R14: Load rising edge starts the display test
// R15: All timing from one clock input
// R16: Far side drives pins only under strobes/load
`default_nettype none

module rcdp_device #(
    parameter int NUM_PORTS   = rcdp_pkg::NUM_PORTS_DEF,
    parameter int HOLD_CYCLES = rcdp_pkg::HOLD_CYCLES_DEF,
    parameter int TEST_SCANS  = rcdp_pkg::TEST_SCANS_DEF
) (
    input  wire logic                                        clk_sys,  // R15
    input  wire logic                                        rst,
    rcdp_if.device                                           bus,
    input  wire logic [NUM_PORTS*rcdp_pkg::STAT_W-1:0]       port_status,
    input  wire logic                                        packet_start,
    input  wire logic                                        packet_end,
    output logic [rcdp_pkg::DATA_W-1:0]                      config_value,
    output logic                                             config_valid,
    output logic                                             display_test,
    output logic                                             display_frozen,
    output logic [rcdp_pkg::REG_COUNT*rcdp_pkg::NIB_W-1:0]   reg_values,
    output logic                                             reg_wr_pulse,
    output logic [rcdp_pkg::NIB_W-1:0]                       reg_wr_addr
);
    import rcdp_pkg::*;

    typedef enum logic [1:0] {
        DISP_SETUP,
        DISP_LATCH,
        DISP_RELEASE
    } rcdp_disp_e;

    localparam int TEST_W = $clog2(TEST_SCANS + 1);
    localparam logic [TEST_W-1:0] TEST_LOAD = TEST_W'(TEST_SCANS);
    localparam logic [TEST_W-1:0] TEST_ONE  = TEST_W'(1);
    localparam logic [PIDX_W-1:0] PIDX_LAST = PIDX_W'(NUM_PORTS - 1);
    localparam logic [PIDX_W-1:0] PIDX_ONE  = PIDX_W'(1);

    ////////////////////////////////////////////////////////////////////////
    // Cycle classification
    logic cpu_store;
    logic cpu_fetch;
    logic cpu_cycle;
    logic load_held;
    logic core_rst;
    logic load_rise;

    assign cpu_store = ~bus.reg_store_n;
    assign cpu_fetch = ~bus.reg_fetch_n;
    assign cpu_cycle = cpu_store | cpu_fetch;
    assign load_held = ~bus.config_load_reset_n;
    assign core_rst  = rst | load_held;  // R12

    ////////////////////////////////////////////////////////////////////////
    // Configuration load
    logic                load_prev_reg;
    logic [DATA_W-1:0]   cfg_shadow_reg;
    logic [DATA_W-1:0]   cfg_reg;
    logic                cfg_valid_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            load_prev_reg <= 1'b1;
        end else begin
            load_prev_reg <= bus.config_load_reset_n;
        end
    end

    assign load_rise = bus.config_load_reset_n & ~load_prev_reg;

    // Pins sampled while held; last held value taken at release
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_shadow_reg <= CFG_RESET;
            cfg_reg        <= CFG_RESET;
            cfg_valid_reg  <= 1'b0;
        end else begin
            if (load_held) begin
                cfg_shadow_reg <= bus.d;  // R16
            end
            if (load_rise) begin
                cfg_reg       <= cfg_shadow_reg;  // R13
                cfg_valid_reg <= 1'b1;
            end
        end
    end

    assign config_value = cfg_reg;
    assign config_valid = cfg_valid_reg;

    ////////////////////////////////////////////////////////////////////////
    // Internal register file, written on store release
    logic [NIB_W-1:0] regs_reg [REG_COUNT];
    logic             store_prev_reg;
    logic [NIB_W-1:0] st_addr_reg;
    logic [NIB_W-1:0] st_data_reg;
    logic             wr_pulse_reg;

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            store_prev_reg <= 1'b0;
            st_addr_reg    <= '0;
            st_data_reg    <= '0;
        end else begin
            store_prev_reg <= cpu_store;
            if (cpu_store) begin
                st_addr_reg <= bus.d[DATA_W-1:ADDR_LSB];  // R04
                st_data_reg <= bus.d[NIB_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_reg[i] <= '0;
            end
            wr_pulse_reg <= 1'b0;
        end else begin
            wr_pulse_reg <= 1'b0;
            if (store_prev_reg && !cpu_store) begin
                regs_reg[st_addr_reg] <= st_data_reg;  // R10
                wr_pulse_reg          <= 1'b1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) begin
            reg_values[i*NIB_W +: NIB_W] = regs_reg[i];
        end
    end

    assign reg_wr_pulse = wr_pulse_reg;
    assign reg_wr_addr  = st_addr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Frozen packet status
    logic [STAT_W-1:0] frozen_reg [NUM_PORTS];
    logic              hold_strobe_reg;
    logic              freeze_active;

    rcdp_hold_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_hold_timer (
        .clk_sys (clk_sys),
        .rst     (core_rst),
        .start   (packet_end),
        .stop    (packet_start),
        .active  (freeze_active)
    );

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                frozen_reg[i] <= '0;
            end
            hold_strobe_reg <= 1'b0;
        end else begin
            hold_strobe_reg <= packet_end;  // R06
            if (packet_end) begin
                for (int i = 0; i < NUM_PORTS; i++) begin
                    frozen_reg[i] <= port_status[i*STAT_W +: STAT_W];  // R07
                end
            end
        end
    end

    assign bus.display_hold_strobe = hold_strobe_reg;
    assign display_frozen          = freeze_active;

    ////////////////////////////////////////////////////////////////////////
    // Display scan
    rcdp_disp_e         state_reg;
    logic [PIDX_W-1:0]  port_idx_reg;
    logic [TEST_W-1:0]  test_cnt_reg;
    logic [STAT_W-1:0]  cur_stat;

    always_comb begin
        if (test_cnt_reg != '0 || load_rise) begin
            cur_stat = STAT_TEST;
        end else if (freeze_active) begin
            cur_stat = frozen_reg[port_idx_reg];  // R07
        end else begin
            cur_stat = port_status[port_idx_reg*STAT_W +: STAT_W];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            state_reg    <= DISP_SETUP;
            port_idx_reg <= '0;
        end else if (cpu_cycle) begin
            state_reg <= DISP_SETUP;  // R02
        end else begin
            case (state_reg)
                DISP_SETUP: begin
                    state_reg <= DISP_LATCH;
                end
                DISP_LATCH: begin
                    state_reg <= DISP_RELEASE;
                end
                default: begin
                    state_reg <= DISP_SETUP;
                    if (port_idx_reg == PIDX_LAST) begin
                        port_idx_reg <= '0;
                    end else begin
                        port_idx_reg <= port_idx_reg + PIDX_ONE;
                    end
                end
            endcase
        end
    end

    // Test runs a fixed number of full scans after load release
    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            test_cnt_reg <= '0;
        end else if (load_rise) begin
            test_cnt_reg <= TEST_LOAD;  // R14
        end else if (test_cnt_reg != '0 && !cpu_cycle && state_reg == DISP_RELEASE
                     && port_idx_reg == PIDX_LAST) begin
            test_cnt_reg <= test_cnt_reg - TEST_ONE;
        end
    end

    assign display_test = (test_cnt_reg != '0);

    ////////////////////////////////////////////////////////////////////////
    // Pin drive
    logic [DATA_W-1:0] d_out_reg;

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            d_out_reg <= '0;
        end else if (cpu_fetch) begin
            d_out_reg <= cpu_word(bus.d[DATA_W-1:ADDR_LSB], regs_reg[bus.d[DATA_W-1:ADDR_LSB]]);  // R11
        end else if (!cpu_store && state_reg == DISP_SETUP) begin
            d_out_reg <= disp_word(port_idx_reg, cur_stat);  // R03
        end
    end

    always_comb begin
        if (load_held) begin
            bus.dev_d_oe = OE_NONE;  // R13
        end else if (cpu_fetch) begin
            bus.dev_d_oe = OE_LOW_NIB;  // R04
        end else if (cpu_store) begin
            bus.dev_d_oe = OE_NONE;
        end else begin
            bus.dev_d_oe = OE_ALL;  // R05
        end
    end

    assign bus.dev_d_out = d_out_reg;

    // Latch strobe only pulses in display cycles
    assign bus.display_latch_strobe_n = ~(state_reg == DISP_LATCH && !cpu_cycle && !load_held);  // R01 R02
    assign bus.data_buffer_drive_enable = ~(cpu_cycle | load_held);  // R08 R09

endmodule

`default_nettype wire

// ==== logic/rcdp_host.sv ====
// Processor end of the shared display / processor pin port.
// Assumes the device releases the pins under store strobes and during load, and drives only the low nibble under fetch.
`default_nettype none

module rcdp_host #(
    parameter int STROBE_CYCLES = rcdp_pkg::STROBE_CYCLES_DEF,
    parameter int LOAD_CYCLES   = rcdp_pkg::LOAD_CYCLES_DEF
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    rcdp_if.host                               bus,
    input  wire logic                          cmd_valid,
    output logic                               cmd_ready,
    input  wire logic                          cmd_write,
    input  wire logic [rcdp_pkg::NIB_W-1:0]    cmd_addr,
    input  wire logic [rcdp_pkg::NIB_W-1:0]    cmd_wdata,
    output logic                               rsp_valid,
    output logic [rcdp_pkg::NIB_W-1:0]         rsp_rdata,
    input  wire logic                          load_valid,
    input  wire logic [rcdp_pkg::DATA_W-1:0]   load_value,
    output logic                               disp_valid,
    output logic [rcdp_pkg::DATA_W-1:0]        disp_data,
    output logic                               hold_seen
);
    import rcdp_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE,
        H_SETUP,
        H_STROBE,
        H_LOAD
    } rcdp_host_e;

    localparam int CNT_W = $clog2(LOAD_CYCLES + STROBE_CYCLES + 1);
    localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYCLES - 1);
    localparam logic [CNT_W-1:0] LOAD_LOAD   = CNT_W'(LOAD_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ONE     = CNT_W'(1);

    rcdp_host_e          state_reg;
    logic [CNT_W-1:0]    cnt_reg;
    logic                is_write_reg;
    logic [DATA_W-1:0]   out_reg;
    logic [DATA_W-1:0]   oe_reg;
    logic                store_n_reg;
    logic                fetch_n_reg;
    logic                load_n_reg;
    logic                rsp_valid_reg;
    logic [NIB_W-1:0]    rsp_rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg     <= H_IDLE;
            cnt_reg       <= '0;
            is_write_reg  <= 1'b0;
            out_reg       <= '0;
            oe_reg        <= OE_NONE;
            store_n_reg   <= 1'b1;
            fetch_n_reg   <= 1'b1;
            load_n_reg    <= 1'b1;
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= '0;
        end else begin
            rsp_valid_reg <= 1'b0;
            case (state_reg)
                H_IDLE: begin
                    if (load_valid) begin
                        out_reg    <= load_value;  // R13
                        oe_reg     <= OE_ALL;  // R16
                        load_n_reg <= 1'b0;  // R12
                        cnt_reg    <= LOAD_LOAD;
                        state_reg  <= H_LOAD;
                    end else if (cmd_valid) begin
                        out_reg      <= cpu_word(cmd_addr, cmd_wdata);  // R04
                        is_write_reg <= cmd_write;
                        state_reg    <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    oe_reg      <= is_write_reg ? OE_ALL : OE_HI_NIB;  // R16
                    store_n_reg <= ~is_write_reg;  // R10
                    fetch_n_reg <= is_write_reg;  // R11
                    cnt_reg     <= STROBE_LOAD;
                    state_reg   <= H_STROBE;
                end
                H_STROBE: begin
                    if (cnt_reg == '0) begin
                        store_n_reg <= 1'b1;
                        fetch_n_reg <= 1'b1;
                        oe_reg      <= OE_NONE;  // R16
                        state_reg   <= H_IDLE;
                        if (!is_write_reg) begin
                            rsp_valid_reg <= 1'b1;
                            rsp_rdata_reg <= bus.d[NIB_W-1:0];
                        end
                    end else begin
                        cnt_reg <= cnt_reg - CNT_ONE;
                    end
                end
                default: begin
                    if (cnt_reg == '0) begin
                        load_n_reg <= 1'b1;
                        oe_reg     <= OE_NONE;
                        state_reg  <= H_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - CNT_ONE;
                    end
                end
            endcase
        end
    end

    assign cmd_ready               = (state_reg == H_IDLE) && !load_valid;
    assign rsp_valid               = rsp_valid_reg;
    assign rsp_rdata               = rsp_rdata_reg;
    assign bus.host_d_out          = out_reg;
    assign bus.host_d_oe           = oe_reg;
    assign bus.reg_store_n         = store_n_reg;
    assign bus.reg_fetch_n         = fetch_n_reg;
    assign bus.config_load_reset_n = load_n_reg;

    ////////////////////////////////////////////////////////////////////////
    // Display latch model: captures pins while strobe low
    logic              disp_valid_reg;
    logic [DATA_W-1:0] disp_data_reg;
    logic              hold_seen_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            disp_valid_reg <= 1'b0;
            disp_data_reg  <= '0;
            hold_seen_reg  <= 1'b0;
        end else begin
            disp_valid_reg <= 1'b0;
            hold_seen_reg  <= bus.display_hold_strobe;
            if (!bus.display_latch_strobe_n && bus.data_buffer_drive_enable) begin
                disp_valid_reg <= 1'b1;
                disp_data_reg  <= bus.d;
            end
        end
    end

    assign disp_valid = disp_valid_reg;
    assign disp_data  = disp_data_reg;
    assign hold_seen  = hold_seen_reg;
endmodule

`default_nettype wire

// ==== bench/rcdp_props.sv ====
// Checker for the shared display / processor pin bundle.
// Assumes both ends on clk_sys with rst synchronous, active high.
`default_nettype none

module rcdp_props (
    input wire logic                        clk_sys,
    input wire logic                        rst,
    input wire logic                        display_latch_strobe_n,
    input wire logic                        display_hold_strobe,
    input wire logic                        data_buffer_drive_enable,
    input wire logic                        config_load_reset_n,
    input wire logic                        reg_store_n,
    input wire logic                        reg_fetch_n,
    input wire logic [rcdp_pkg::DATA_W-1:0] dev_d_oe,
    input wire logic [rcdp_pkg::DATA_W-1:0] d
);
    timeunit 1ns;
    timeprecision 1ps;
    import rcdp_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic quiet;
    assign quiet = reg_store_n && reg_fetch_n && config_load_reset_n;

    ////////////////////////////////////////
    sequence cpu_cycle;
        !reg_store_n || !reg_fetch_n;
    endsequence
    sequence latch_then_quiet;
        (!display_latch_strobe_n && quiet) ##1 quiet;
    endsequence
    sequence scan_gap;
        (!display_latch_strobe_n && quiet) ##1 quiet [*3];
    endsequence

    ////////////////////////////////////////
    latch_idle_cpu_a: assert property (cpu_cycle |-> display_latch_strobe_n)
        else $error("latch strobe low in cpu cycle");
    buf_low_cpu_a: assert property (!quiet |-> !data_buffer_drive_enable)
        else $error("buffer enable high in access");
    buf_high_disp_a: assert property (quiet |-> data_buffer_drive_enable)
        else $error("buffer enable low in display cycle");
    pins_driven_a: assert property (quiet |-> dev_d_oe == OE_ALL)
        else $error("pins not driven in display");
    store_free_a: assert property (!reg_store_n |-> dev_d_oe == OE_NONE)
        else $error("device drives pins under store");
    fetch_nib_a: assert property (!reg_fetch_n |-> dev_d_oe == OE_LOW_NIB)
        else $error("wrong pin drive under fetch");
    latch_pulse_a: assert property ($fell(display_latch_strobe_n) |=> display_latch_strobe_n)
        else $error("latch strobe too long");
    scan_pace_a: assert property (scan_gap |-> !display_latch_strobe_n)
        else $error("latch strobe off pace");
    word_stable_a: assert property (latch_then_quiet |-> $stable(d))
        else $error("display word moved");
    hold_pulse_a: assert property ($rose(display_hold_strobe) |=> !display_hold_strobe)
        else $error("hold strobe too long");
    load_quiet_a: assert property (!config_load_reset_n |-> display_latch_strobe_n)
        else $error("latch strobe in load");
endmodule

`default_nettype wire

// ==== bench/repeater_cpu_display_port_test.sv ====
// Bench joining host end and device end through the pin bundle.
// Assumes package, bundle and both ends compiled first.
`default_nettype none

module repeater_cpu_display_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rcdp_pkg::*;
    localparam int HOLD = 50;

    logic        clk_sys = 1'h0, rst = 1'h1, packet_start = 1'h0, packet_end = 1'h0;
    logic        cmd_valid = 1'h0, cmd_write = 1'h0, load_valid = 1'h0;
    logic [3:0]  cmd_addr = 4'h0, cmd_wdata = 4'h0, reg_wr_addr, rsp_rdata, mdl [16];
    logic [7:0]  load_value = 8'h0, config_value, disp_data, w;
    logic [34:0] port_status = 35'h0;
    logic [63:0] reg_values;
    logic        cmd_ready, rsp_valid, disp_valid, hold_seen, config_valid;
    logic        display_test, display_frozen, reg_wr_pulse;
    logic [31:0] rs = 32'd37515;
    logic [3:0]  rd_q [$];
    logic [7:0]  wr_q [$];
    int          err_total = 0, tests_run = 0, cyc = 0;

    always #20 clk_sys = ~clk_sys;

    rcdp_if bus ();
    rcdp_device #(.NUM_PORTS(7), .HOLD_CYCLES(HOLD), .TEST_SCANS(4)) u_rcdp_device (
        .clk_sys(clk_sys), .rst(rst), .bus(bus.device), .port_status(port_status),
        .packet_start(packet_start), .packet_end(packet_end), .config_value(config_value),
        .config_valid(config_valid), .display_test(display_test), .display_frozen(display_frozen),
        .reg_values(reg_values), .reg_wr_pulse(reg_wr_pulse), .reg_wr_addr(reg_wr_addr));
    rcdp_host u_rcdp_host (
        .clk_sys(clk_sys), .rst(rst), .bus(bus.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .load_valid(load_valid), .load_value(load_value),
        .disp_valid(disp_valid), .disp_data(disp_data), .hold_seen(hold_seen));
    rcdp_props u_rcdp_props (
        .clk_sys(clk_sys), .rst(rst), .display_latch_strobe_n(bus.display_latch_strobe_n),
        .display_hold_strobe(bus.display_hold_strobe), .dev_d_oe(bus.dev_d_oe), .d(bus.d),
        .data_buffer_drive_enable(bus.data_buffer_drive_enable), .reg_store_n(bus.reg_store_n),
        .config_load_reset_n(bus.config_load_reset_n), .reg_fetch_n(bus.reg_fetch_n));

    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Caller lowers cmd_valid after the last request
    task automatic cmd(input logic wr, input logic [3:0] a, input logic [3:0] v);
        cmd_valid <= 1'h1;
        cmd_write <= wr;
        cmd_addr <= a;
        cmd_wdata <= v;
        do @(posedge clk_sys); while (cmd_ready !== 1'h1);
    endtask

    ////////////////////////////////////////
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    always @(negedge clk_sys) begin
        if (rsp_valid === 1'h1) chk(rsp_rdata, rd_q.pop_front());
        if (reg_wr_pulse === 1'h1) begin
            w = wr_q.pop_front();
            chk(reg_wr_addr, w[7:4]);
            chk(reg_values[w[7:4]*4 +: 4], w[3:0]);
        end
        if (disp_valid === 1'h1 && display_test === 1'h0)
            chk(disp_data[4:0], port_status[disp_data[7:5]*5 +: 5]);
        else if (disp_valid === 1'h1) chk(disp_data[4:0], STAT_TEST);
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'h0;
        rs = xs(rs);
        port_status <= {rs[2:0], rs};
        repeat (80) @(posedge clk_sys);
        for (int i = 0; i < 16; i++) begin
            rs = xs(rs);
            mdl[i] = rs[3:0];
            wr_q.push_back({i[3:0], rs[3:0]});
            cmd(1'h1, i[3:0], rs[3:0]);
        end
        for (int i = 15; i >= 0; i--) begin
            rd_q.push_back(mdl[i]);
            cmd(1'h0, i[3:0], 4'h0);
        end
        cmd_valid <= 1'h0;
        repeat (20) @(posedge clk_sys);
        chk(rd_q.size() + wr_q.size(), 0);
        for (int k = 0; k < 2; k++) begin
            packet_end <= 1'h1;
            @(posedge clk_sys);
            packet_end <= 1'h0;
            @(negedge clk_sys);
            chk({bus.display_hold_strobe, display_frozen}, 2'h3);
            @(negedge clk_sys);
            chk(hold_seen, 1'h1);
            repeat (k ? 5 : HOLD - 5) @(posedge clk_sys);
            chk(display_frozen, 1'h1);
            packet_start <= k[0];
            @(posedge clk_sys);
            packet_start <= 1'h0;
            repeat (k ? 3 : 12) @(posedge clk_sys);
            chk(display_frozen, 1'h0);
        end
        for (int k = 0; k < 2; k++) begin
            rs = xs(rs);
            load_value <= rs[7:0];
            load_valid <= 1'h1;
            @(posedge clk_sys);
            load_valid <= 1'h0;
            port_status <= {rs[2:0], rs};
            repeat (13) @(posedge clk_sys);
            chk({config_valid, config_value}, {1'h1, rs[7:0]});
            chk(display_test, 1'h1);
            chk(reg_values, 64'h0);
            repeat (120) @(posedge clk_sys);
        end
        wr_q.push_back(8'hA5);
        cmd(1'h1, 4'hA, 4'h5);
        rd_q.push_back(4'h5);
        cmd(1'h0, 4'hA, 4'h0);
        cmd_valid <= 1'h0;
        repeat (20) @(posedge clk_sys);
        chk(rd_q.size() + wr_q.size(), 0);
        summarize();
    end
endmodule

`default_nettype wire
